// ==== verilog/psc_pkg.sv ====
// Purpose: shared constants and types for the position switch bank
// Assumes: one servo clock, synchronous active-high reset
// Notes: enable codes match the software encoding of the enable field
package psc_pkg;
  localparam int NUM_SWITCHES = 16;
  localparam int SW_IDX_W = 4;
  localparam int NUM_AXES = 4;
  localparam int POS_W = 32;
  localparam int USER_W = 24;
  localparam int UNITS_W = 16;
  localparam int OUT_W = 32;
  localparam int LINE_W = 5;
  localparam int HW_OUT_W = 4;
  localparam int HW_LINE_W = 2;
  localparam int EN_W = 2;
  localparam logic [UNITS_W-1:0] UNITS_RESET = 16'h0001;
  localparam logic [POS_W-1:0] POS_RESET = 32'h0000_0000;
  localparam logic [OUT_W-1:0] PHYS_OUT_MASK = 32'hFFFF_FF00;
  localparam logic [LINE_W-1:0] LINE_RESET = 5'h00;
  localparam logic ACTIVE_ON = 1'b1;
  // 2'b10 is not a valid enable code and decodes as off
  typedef enum logic [EN_W-1:0] {
    PSC_OFF = 2'b00,
    PSC_SW = 2'b01,
    PSC_HW = 2'b11
  } psc_mode_e;
endpackage

// ==== verilog/psc_quad.sv ====
// Purpose: quadrature decoder and position counter for one axis
// Assumes: encoder pins are asynchronous to the servo clock
// Notes: a double transition in one cycle is dropped, not guessed
`timescale 1ns/1ps
module psc_quad #(
  parameter int POS_W = 32
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic enc_a_i,
  input wire logic enc_b_i,
  output logic [POS_W-1:0] pos_o
);
  logic a_s1_q;
  logic a_s2_q;
  logic b_s1_q;
  logic b_s2_q;
  logic a_p_q;
  logic b_p_q;
  logic [POS_W-1:0] pos_q;
  logic [POS_W-1:0] pos_d;
  logic step;
  logic up;

  always_comb
  begin
    // every edge of either channel counts: four counts per line
    step = (a_s2_q ^ a_p_q) ^ (b_s2_q ^ b_p_q); // RULE_14
    up = a_s2_q ^ b_p_q;
    pos_d = pos_q;
    if (step)
    begin
      pos_d = up ? pos_q + POS_W'(1) : pos_q - POS_W'(1); // RULE_14
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      a_s1_q <= 1'b0;
      a_s2_q <= 1'b0;
      b_s1_q <= 1'b0;
      b_s2_q <= 1'b0;
      a_p_q <= 1'b0;
      b_p_q <= 1'b0;
      pos_q <= '0;
    end
    else
    begin
      a_s1_q <= enc_a_i;
      a_s2_q <= a_s1_q;
      b_s1_q <= enc_b_i;
      b_s2_q <= b_s1_q;
      a_p_q <= a_s2_q;
      b_p_q <= b_s2_q;
      pos_q <= pos_d;
    end
  end

  assign pos_o = pos_q;
endmodule

// ==== verilog/psc_switch.sv ====
// Purpose: one position switch with its own configuration
// Assumes: positions arrive as raw counts on the servo clock
// Notes: compare points are scaled once, when the switch is written
`timescale 1ns/1ps
module psc_switch #(
  parameter int NA = 4,
  parameter int AXIS_W = 2,
  parameter int POS_W = 32,
  parameter int USER_W = 24,
  parameter int UNITS_W = 16,
  parameter int LINE_W = 5
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cfg_we_i,
  input wire logic cfg_full_i,
  input wire logic [1:0] cfg_en_i,
  input wire logic hw_ok_i,
  input wire logic [AXIS_W-1:0] cfg_axis_i,
  input wire logic [LINE_W-1:0] cfg_line_i,
  input wire logic cfg_state_i,
  input wire logic signed [USER_W-1:0] cfg_set_i,
  input wire logic signed [USER_W-1:0] cfg_rst_i,
  input wire logic [UNITS_W-1:0] units_i,
  input wire logic [NA-1:0][POS_W-1:0] pos_i,
  input wire logic clear_i,
  output psc_pkg::psc_mode_e mode_o,
  output logic hw_o,
  output logic [LINE_W-1:0] line_o,
  output logic drive_d_o,
  output logic drive_o
);
  localparam int PROD_W = USER_W + UNITS_W + 1;
  psc_pkg::psc_mode_e mode_q;
  psc_pkg::psc_mode_e mode_d;
  psc_pkg::psc_mode_e mode_new;
  logic hw_q;
  logic hw_d;
  logic [AXIS_W-1:0] axis_q;
  logic [AXIS_W-1:0] axis_d;
  logic [LINE_W-1:0] line_q;
  logic [LINE_W-1:0] line_d;
  logic state_q;
  logic state_d;
  logic [POS_W-1:0] set_q;
  logic [POS_W-1:0] set_d;
  logic [POS_W-1:0] rst_q;
  logic [POS_W-1:0] rst_d;
  logic drive_q;
  logic drive_d;
  logic [POS_W-1:0] pos;
  logic signed [PROD_W-1:0] prod_set;
  logic signed [PROD_W-1:0] prod_rst;

  always_comb
  begin
    unique case (cfg_en_i)
      2'b01: mode_new = psc_pkg::PSC_SW; // RULE_05
      // hardware compare needs the expansion board
      2'b11: mode_new = hw_ok_i ? psc_pkg::PSC_HW
        : psc_pkg::PSC_OFF; // RULE_10
      default: mode_new = psc_pkg::PSC_OFF; // RULE_05
    endcase
    // user units times axis factor gives raw counts
    prod_set = cfg_set_i * $signed({1'b0, units_i}); // RULE_13
    prod_rst = cfg_rst_i * $signed({1'b0, units_i}); // RULE_13
    pos = pos_i[axis_q]; // RULE_02
    mode_d = mode_q;
    hw_d = hw_q;
    axis_d = axis_q;
    line_d = line_q;
    state_d = state_q;
    set_d = set_q;
    rst_d = rst_q;
    drive_d = drive_q;
    if (mode_q != psc_pkg::PSC_OFF)
    begin
      if (pos == rst_q)
      begin
        drive_d = 1'b0; // RULE_03
      end
      // set is checked last so it wins if both points coincide
      if (pos == set_q)
      begin
        drive_d = (state_q == psc_pkg::ACTIVE_ON); // RULE_03 RULE_12
      end
    end
    else if (clear_i)
    begin
      // a disabled switch keeps its level until software clears it
      drive_d = 1'b0; // RULE_15
    end
    if (cfg_we_i)
    begin
      mode_d = mode_new;
      if (cfg_full_i)
      begin
        hw_d = (mode_new == psc_pkg::PSC_HW);
        axis_d = cfg_axis_i;
        line_d = cfg_line_i;
        state_d = cfg_state_i;
        set_d = prod_set[POS_W-1:0]; // RULE_13
        rst_d = prod_rst[POS_W-1:0]; // RULE_13
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mode_q <= psc_pkg::PSC_OFF;
      hw_q <= 1'b0;
      axis_q <= '0;
      line_q <= '0;
      state_q <= 1'b0;
      set_q <= '0;
      rst_q <= '0;
      drive_q <= 1'b0;
    end
    else
    begin
      mode_q <= mode_d;
      hw_q <= hw_d;
      axis_q <= axis_d;
      line_q <= line_d;
      state_q <= state_d;
      set_q <= set_d;
      rst_q <= rst_d;
      drive_q <= drive_d;
    end
  end

  assign mode_o = mode_q;
  assign hw_o = hw_q;
  assign line_o = line_q;
  assign drive_d_o = drive_d;
  assign drive_o = drive_q;
endmodule

// ==== verilog/psc_top.sv ====
// Purpose: bank of position compare switches driving output lines
// Assumes: 25 MHz servo clock, encoder and strap pins asynchronous
// Notes: outputs 0..7 do not exist and always read as zero
//
// Notes on behaviour
// RULE_01: sixteen switches, each separately configured by index
// RULE_02: each switch may watch any axis
// RULE_03: set point asserts output, reset point releases
// RULE_04: output is OR of switches and software
// RULE_05: enable 1 software, 0 off, 3 hardware
// RULE_06: enabling needs all values; disabling needs two
// RULE_07: software mode targets outputs 8 to 31
// RULE_08: hardware mode targets local outputs 0 to 3
// RULE_09: hardware mode axis means hardware slot number; the code uses it as the axis index in both modes
// RULE_10: hardware mode only with expansion board fitted
// RULE_11: software mode axis within present axes
// RULE_12: state 1 drives on, otherwise off
// RULE_13: user-unit positions scaled by axis factor
// RULE_14: counter counts four edges per encoder line
// RULE_15: disabling leaves output level until software clears
// RULE_16: outputs 0 to 7 absent, read zero
// RULE_17: all switches evaluated and combined each cycle
`timescale 1ns/1ps
module psc_top #(
  parameter int NA = psc_pkg::NUM_AXES,
  parameter int AXIS_W = $clog2(NA)
) (
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  input wire logic [NA-1:0] ENC_A_I,
  input wire logic [NA-1:0] ENC_B_I,
  input wire logic EXP_BOARD_FITTED_I,
  input wire logic UNITS_WE_I,
  input wire logic [AXIS_W-1:0] UNITS_AXIS_I,
  input wire logic [psc_pkg::UNITS_W-1:0] UNITS_FACTOR_I,
  input wire logic SW_OUT_WE_I,
  input wire logic [psc_pkg::LINE_W-1:0] SW_OUT_LINE_I,
  input wire logic SW_OUT_VALUE_I,
  input wire logic CFG_WE_I,
  input wire logic CFG_FULL_I,
  input wire logic [psc_pkg::SW_IDX_W-1:0] CFG_SWITCH_INDEX_I,
  input wire logic [psc_pkg::EN_W-1:0] CFG_ENABLE_I,
  input wire logic [AXIS_W-1:0] CFG_AXIS_I,
  input wire logic [psc_pkg::LINE_W-1:0] CFG_OUTPUT_NO_I,
  input wire logic CFG_OUTPUT_STATE_I,
  input wire logic [psc_pkg::USER_W-1:0] CFG_SET_POS_I,
  input wire logic [psc_pkg::USER_W-1:0] CFG_RESET_POS_I,
  output logic [psc_pkg::OUT_W-1:0] OUT_O,
  output logic [psc_pkg::HW_OUT_W-1:0] HW_OUT_O,
  output logic [psc_pkg::OUT_W-1:0] SW_OUT_RD_O,
  output logic [psc_pkg::NUM_SWITCHES-1:0] SWITCH_ENABLED_O,
  output logic [psc_pkg::NUM_SWITCHES-1:0] SWITCH_DRIVE_O,
  output logic [NA*psc_pkg::POS_W-1:0] AXIS_POS_O
);
  localparam int NS = psc_pkg::NUM_SWITCHES;
  localparam int LW = psc_pkg::LINE_W;
  localparam int OW = psc_pkg::OUT_W;
  localparam int HW = psc_pkg::HW_OUT_W;

  logic fit_s1_q;
  logic fit_s2_q;
  logic [NA-1:0][psc_pkg::POS_W-1:0] pos;
  logic [NA-1:0][psc_pkg::UNITS_W-1:0] units_q;
  logic [NA-1:0][psc_pkg::UNITS_W-1:0] units_d;
  logic [OW-1:0] sw_out_q;
  logic [OW-1:0] sw_out_d;
  logic [OW-1:0] out_q;
  logic [OW-1:0] out_d;
  logic [HW-1:0] hw_out_q;
  logic [HW-1:0] hw_out_d;
  logic [NS-1:0] sw_we;
  logic [NS-1:0] sw_clear;
  logic [NS-1:0] sw_hw;
  logic [NS-1:0] sw_drive_d;
  logic [NS-1:0] sw_drive_q;
  logic [NS-1:0][LW-1:0] sw_line;
  psc_pkg::psc_mode_e sw_mode [NS];
  logic [psc_pkg::UNITS_W-1:0] cfg_units;

  // the board strap is a pin, so it is synchronised before use
  always_ff @(posedge SYS_CLK_I)
  begin
    if (RST_I)
    begin
      fit_s1_q <= 1'b0;
      fit_s2_q <= 1'b0;
    end
    else
    begin
      fit_s1_q <= EXP_BOARD_FITTED_I;
      fit_s2_q <= fit_s1_q;
    end
  end

  genvar a;
  generate
    for (a = 0; a < NA; a++)
    begin : g_axis
      psc_quad #(
        .POS_W(psc_pkg::POS_W)
      ) u_quad (
        .clk_i(SYS_CLK_I),
        .rst_i(RST_I),
        .enc_a_i(ENC_A_I[a]),
        .enc_b_i(ENC_B_I[a]),
        .pos_o(pos[a])
      );
      assign AXIS_POS_O[a*psc_pkg::POS_W +: psc_pkg::POS_W] = pos[a];
    end
  endgenerate

  // unit conversion factor per axis
  always_comb
  begin
    units_d = units_q;
    if (UNITS_WE_I)
    begin
      units_d[UNITS_AXIS_I] = UNITS_FACTOR_I;
    end
  end

  always_ff @(posedge SYS_CLK_I)
  begin
    if (RST_I)
    begin
      units_q <= {NA{psc_pkg::UNITS_RESET}};
    end
    else
    begin
      units_q <= units_d;
    end
  end

  // the factor is taken at configuration time; a later factor change
  // needs the switch to be written again
  assign cfg_units = units_q[CFG_AXIS_I]; // RULE_13

  genvar s;
  generate
    for (s = 0; s < NS; s++)
    begin : g_switch
      assign sw_we[s] = CFG_WE_I &&
        (CFG_SWITCH_INDEX_I == psc_pkg::SW_IDX_W'(s)); // RULE_01
      // only an explicit software off releases a disabled switch
      assign sw_clear[s] = SW_OUT_WE_I && !SW_OUT_VALUE_I && !sw_hw[s] &&
        (sw_line[s] == SW_OUT_LINE_I); // RULE_15
      psc_switch #(
        .NA(NA),
        .AXIS_W(AXIS_W),
        .POS_W(psc_pkg::POS_W),
        .USER_W(psc_pkg::USER_W),
        .UNITS_W(psc_pkg::UNITS_W),
        .LINE_W(LW)
      ) u_switch (
        .clk_i(SYS_CLK_I),
        .rst_i(RST_I),
        .cfg_we_i(sw_we[s]),
        .cfg_full_i(CFG_FULL_I),
        .cfg_en_i(CFG_ENABLE_I),
        .hw_ok_i(fit_s2_q),
        .cfg_axis_i(CFG_AXIS_I),
        .cfg_line_i(CFG_OUTPUT_NO_I),
        .cfg_state_i(CFG_OUTPUT_STATE_I),
        .cfg_set_i(CFG_SET_POS_I),
        .cfg_rst_i(CFG_RESET_POS_I),
        .units_i(cfg_units),
        .pos_i(pos),
        .clear_i(sw_clear[s]),
        .mode_o(sw_mode[s]),
        .hw_o(sw_hw[s]),
        .line_o(sw_line[s]),
        .drive_d_o(sw_drive_d[s]),
        .drive_o(sw_drive_q[s])
      );
      assign SWITCH_ENABLED_O[s] = (sw_mode[s] != psc_pkg::PSC_OFF);
    end
  endgenerate

  // software output setting; absent lines never store
  always_comb
  begin
    sw_out_d = sw_out_q;
    if (SW_OUT_WE_I)
    begin
      sw_out_d[SW_OUT_LINE_I] = SW_OUT_VALUE_I;
    end
    sw_out_d = sw_out_d & psc_pkg::PHYS_OUT_MASK; // RULE_16
  end

  // combine from next-cycle switch levels so a crossing lands at once
  always_comb
  begin
    out_d = sw_out_d; // RULE_04
    hw_out_d = '0;
    for (int i = 0; i < NS; i++)
    begin
      if (sw_drive_d[i]) // RULE_17
      begin
        if (sw_hw[i])
        begin
          hw_out_d[sw_line[i][psc_pkg::HW_LINE_W-1:0]] = 1'b1; // RULE_08
        end
        else
        begin
          out_d[sw_line[i]] = 1'b1; // RULE_04 RULE_07
        end
      end
    end
    out_d = out_d & psc_pkg::PHYS_OUT_MASK; // RULE_16
  end

  always_ff @(posedge SYS_CLK_I)
  begin
    if (RST_I)
    begin
      sw_out_q <= '0;
      out_q <= '0;
      hw_out_q <= '0;
    end
    else
    begin
      sw_out_q <= sw_out_d;
      out_q <= out_d;
      hw_out_q <= hw_out_d;
    end
  end

  assign OUT_O = out_q;
  assign HW_OUT_O = hw_out_q;
  assign SW_OUT_RD_O = sw_out_q; // RULE_16
  assign SWITCH_DRIVE_O = sw_drive_q;
endmodule

// ==== bench/psc_chk.sv ====
// Purpose: port checker for the position switch bank
// Assumes: one servo clock, reset high
// Notes: the strap is looked at two samples back, past its two-stage sync
`timescale 1ns/1ps
module psc_chk (
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  input wire logic EXP_BOARD_FITTED_I,
  input wire logic SW_OUT_WE_I,
  input wire logic [4:0] SW_OUT_LINE_I,
  input wire logic SW_OUT_VALUE_I,
  input wire logic CFG_WE_I,
  input wire logic [3:0] CFG_SWITCH_INDEX_I,
  input wire logic [1:0] CFG_ENABLE_I,
  input wire logic [31:0] OUT_O,
  input wire logic [31:0] SW_OUT_RD_O,
  input wire logic [15:0] SWITCH_ENABLED_O
);
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (RST_I);
  chk_out_low_zero: assert property (OUT_O[7:0] == 8'h00)
    else $error("out low lines set");
  chk_rd_low_zero: assert property (SW_OUT_RD_O[7:0] == 8'h00)
    else $error("readback low lines set");
  chk_sw_write: assert property (
    SW_OUT_WE_I && SW_OUT_LINE_I > 5'h07 |=>
    SW_OUT_RD_O[$past(SW_OUT_LINE_I)] == $past(SW_OUT_VALUE_I))
    else $error("software output not stored");
  chk_or_soft: assert property (
    (SW_OUT_RD_O & ~OUT_O) == 32'h0000_0000)
    else $error("software setting missing from out");
  chk_en_off: assert property (CFG_WE_I && !CFG_ENABLE_I[0] |=>
    !SWITCH_ENABLED_O[$past(CFG_SWITCH_INDEX_I)])
    else $error("off code left switch on");
  chk_en_soft: assert property (
    CFG_WE_I && CFG_ENABLE_I == 2'h1 |=>
    SWITCH_ENABLED_O[$past(CFG_SWITCH_INDEX_I)])
    else $error("software code not enabled");
  // the synced strap seen at an edge is the pin two edges earlier
  chk_hw_absent: assert property (
    CFG_WE_I && CFG_ENABLE_I == 2'h3 && !$past(EXP_BOARD_FITTED_I, 2) |=>
    !SWITCH_ENABLED_O[$past(CFG_SWITCH_INDEX_I)])
    else $error("hardware mode without board");
  // a reset in the last two edges empties the strap sync
  chk_hw_present: assert property (
    CFG_WE_I && CFG_ENABLE_I == 2'h3 && $past(EXP_BOARD_FITTED_I, 2) &&
    !$past(RST_I) && !$past(RST_I, 2) |=>
    SWITCH_ENABLED_O[$past(CFG_SWITCH_INDEX_I)])
    else $error("hardware mode refused with board");
endmodule
bind psc_top psc_chk u_psc_chk (.SYS_CLK_I, .RST_I, .EXP_BOARD_FITTED_I,
  .SW_OUT_WE_I, .SW_OUT_LINE_I, .SW_OUT_VALUE_I, .CFG_WE_I,
  .CFG_SWITCH_INDEX_I, .CFG_ENABLE_I, .OUT_O, .SW_OUT_RD_O,
  .SWITCH_ENABLED_O);

// ==== bench/psc_enc_model.sv ====
// Purpose: quadrature encoder model for the axes
// Assumes: caller enters a step at a falling edge
// Notes: phase order 00,10,11,01 counts up
`timescale 1ns/1ps
module psc_enc_model (
  input wire logic clk_i,
  output logic [3:0] enc_a_o,
  output logic [3:0] enc_b_o
);
  logic [1:0] ph [4];
  initial
  begin
    enc_a_o = 4'h0;
    enc_b_o = 4'h0;
    foreach (ph[i]) ph[i] = 2'h0;
  end
  // one pin per step, so no step is ever a dropped double change
  task automatic step(input int ax, input bit up, input int gap);
    ph[ax] = up ? ph[ax] + 2'h1 : ph[ax] - 2'h1;
    enc_a_o[ax] = ph[ax] == 2'h1 || ph[ax] == 2'h2;
    enc_b_o[ax] = ph[ax][1];
    repeat (gap) @(negedge clk_i);
  endtask
endmodule

// ==== bench/tb.sv ====
// Purpose: self-checking bench for the position switch bank
// Assumes: 25 MHz clock, inputs driven on the falling edge
// Notes: one task per scenario
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] ea, eb;
  logic brd = 1'b0, uwe = 1'b0, owe = 1'b0, oval = 1'b0;
  logic [1:0] uax = 2'h0, cen = 2'h0, cax = 2'h0;
  logic [15:0] ufac = 16'h0001;
  logic [4:0] oln = 5'h00, cln = 5'h00;
  logic cwe = 1'b0, cfull = 1'b0, cst = 1'b0;
  logic [3:0] cidx = 4'h0;
  logic [23:0] cset = 24'h00_0000, crst = 24'h00_0000;
  logic [31:0] out, rd;
  logic [3:0] hw;
  logic [15:0] ena, drv;
  logic [127:0] pos;
  int err_count = 0;
  int n_tests = 0;
  int p [4];
  always #20 clk = ~clk;
  psc_enc_model u_psc_enc_model (.clk_i(clk), .enc_a_o(ea), .enc_b_o(eb));
  psc_top u_psc_top (.SYS_CLK_I(clk), .RST_I(rst), .ENC_A_I(ea),
    .ENC_B_I(eb), .EXP_BOARD_FITTED_I(brd), .UNITS_WE_I(uwe),
    .UNITS_AXIS_I(uax), .UNITS_FACTOR_I(ufac), .SW_OUT_WE_I(owe),
    .SW_OUT_LINE_I(oln), .SW_OUT_VALUE_I(oval), .CFG_WE_I(cwe),
    .CFG_FULL_I(cfull), .CFG_SWITCH_INDEX_I(cidx), .CFG_ENABLE_I(cen),
    .CFG_AXIS_I(cax), .CFG_OUTPUT_NO_I(cln), .CFG_OUTPUT_STATE_I(cst),
    .CFG_SET_POS_I(cset), .CFG_RESET_POS_I(crst), .OUT_O(out),
    .HW_OUT_O(hw), .SW_OUT_RD_O(rd), .SWITCH_ENABLED_O(ena),
    .SWITCH_DRIVE_O(drv), .AXIS_POS_O(pos));
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic give_verdict();
    $display("tests %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic cfg(input logic [3:0] i, input logic [1:0] e,
    input logic f, input logic [1:0] a, input logic [4:0] l,
    input logic s, input logic [23:0] st, rs);
    cidx = i;
    cen = e;
    cfull = f;
    cax = a;
    cln = l;
    cst = s;
    cset = st;
    crst = rs;
    cwe = 1'b1;
    @(negedge clk);
    cwe = 1'b0;
    @(negedge clk);
  endtask
  task automatic sop(input logic [4:0] l, input logic v);
    oln = l;
    oval = v;
    owe = 1'b1;
    @(negedge clk);
    owe = 1'b0;
    @(negedge clk);
  endtask
  // equality compare only, so the sweep moves one count at a time
  task automatic sweep(input int ax, n, lo, hi, b, input bit h);
    logic [31:0] v;
    for (int k = 0; k < n; k++)
    begin
      u_psc_enc_model.step(ax, 1'b1, 6);
      p[ax]++;
      v = h ? {28'h000_0000, hw} : out;
      chk("line", {31'h0, p[ax] >= lo && p[ax] < hi},
        {31'h0, v[b]});
      chk("pos", p[ax], pos[ax*32+:32]);
    end
  endtask
  task automatic t_reset();
    chk("out", 32'h0000_0000, out);
    chk("rd", 32'h0000_0000, rd);
    chk("hw", 32'h0000_0000, {28'h000_0000, hw});
    chk("ena", 32'h0000_0000, {16'h0000, ena});
    chk("drv", 32'h0000_0000, {16'h0000, drv});
    chk("pos0", 32'h0000_0000, pos[31:0]);
  endtask
  task automatic t_soft_out();
    sop(5'h03, 1'b1);
    chk("rd low", 32'h0000_0000, rd);
    sop(5'h09, 1'b1);
    chk("out9", 32'h0000_0200, out);
    sop(5'h09, 1'b0);
    chk("out9 off", 32'h0000_0000, out);
  endtask
  task automatic t_modes();
    for (int c = 0; c < 4; c++)
    begin
      cfg(4'h5, c[1:0], 1'b1, 2'h0, 5'h08, 1'b1, 24'h00_0064, 24'h00_0065);
      chk("ena5", {31'h0, c == 1}, {31'h0, ena[5]});
    end
    brd = 1'b1;
    repeat (3) @(negedge clk);
    cfg(4'h5, 2'h3, 1'b1, 2'h0, 5'h00, 1'b1, 24'h00_0064, 24'h00_0065);
    chk("ena5 hw", 32'h0000_0001, {31'h0, ena[5]});
    cfg(4'h5, 2'h0, 1'b0, 2'h3, 5'h1F, 1'b0, 24'h00_0000, 24'h00_0000);
    chk("ena5 off", 32'h0000_0000, {31'h0, ena[5]});
  endtask
  task automatic t_cross();
    ufac = 16'h000A;
    uwe = 1'b1;
    @(negedge clk);
    uwe = 1'b0;
    @(negedge clk);
    cfg(4'h0, 2'h1, 1'b1, 2'h0, 5'h0B, 1'b1,
      24'h00_0002, 24'h00_0005);
    // same points, state 0: line 12 must stay off through the set point
    cfg(4'h1, 2'h1, 1'b1, 2'h0, 5'h0C, 1'b0,
      24'h00_0002, 24'h00_0005);
    sweep(0, 25, 20, 50, 11, 1'b0);
    cfg(4'h0, 2'h0, 1'b0, 2'h3, 5'h00, 1'b0, 24'h00_0000, 24'h00_0000);
    chk("held", 32'h0000_0800, out);
    chk("drv held", 32'h0000_0001, {16'h0000, drv});
    sop(5'h0B, 1'b0);
    chk("cleared", 32'h0000_0000, out);
    chk("drv clr", 32'h0000_0000, {16'h0000, drv});
  endtask
  task automatic t_hard();
    cfg(4'hF, 2'h3, 1'b1, 2'h1, 5'h02, 1'b1,
      24'h00_0003, 24'h00_0006);
    sweep(1, 8, 3, 6, 2, 1'b1);
  endtask
  initial
  begin
    repeat (4) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    t_reset();
    t_soft_out();
    t_modes();
    t_cross();
    t_hard();
    give_verdict();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    give_verdict();
  end
endmodule
